// File: src/ssw_defines.svh
// Purpose: offsets, field positions, reset values and counts of the supervisor
// Assumes: 32-bit APB data, one aligned word per register
// Notes: definitions only
`ifndef SSW_DEFINES_SVH
`define SSW_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SSW_OFF_CLKCN 12'h000
`define SSW_OFF_WATCHDOG_CONTROL_REG 12'h004
`define SSW_OFF_IRQEN 12'h008
`define SSW_OFF_IRQFL 12'h00c
`define SSW_OFF_STAT 12'h010
// ----------------------------------------
// clock control fields
// ----------------------------------------
`define SSW_CLK_SRC 0
`define SSW_CLK_X16 2
`define SSW_CLK_DIV 3
`define SSW_CLK_SLOW 5
`define SSW_CLK_SWB 6
`define SSW_CLK_STOP 7
`define SSW_CLK_WAITX 8
`define SSW_CLK_ARPD 9
`define SSW_CLKCN_RST 10'h200
// ----------------------------------------
// watchdog control fields
// ----------------------------------------
`define SSW_WD_EN 0
`define SSW_WD_RSTEN 1
`define SSW_WD_SEL 2
`define SSW_WD_FLAG 4
`define SSW_WD_POR 7
`define SSW_WATCHDOG_CONTROL_REG_RST 4'h0
// ----------------------------------------
// interrupt enable fields
// ----------------------------------------
`define SSW_IE_WD 3
`define SSW_IE_EXT 4
`define SSW_IE_CAN 5
`define SSW_IE_SPI 6
`define SSW_IE_MSUP 8
`define SSW_IE_MSYS 9
`define SSW_IE_MPER 10
`define SSW_IE_GLB 15
`define SSW_IRQEN_RST 16'h0000
// ----------------------------------------
// values and counts
// ----------------------------------------
`define SSW_RESET_VECTOR 16'h8000
`define SSW_SLOW_DIV_LOG2 4'h8
`define SSW_WD_BASE_LOG2 12
`define SSW_WD_RST_TICKS 512
`define SSW_RST_HOLD 5'h10
`endif

// File: src/ssw_pkg.sv
// Purpose: types shared by the supervisor files
// Assumes: nothing
// Notes: constants live in ssw_defines.svh
package ssw_pkg;
  typedef enum logic [1:0] {
    SSW_RUN = 2'b00,
    SSW_STOPPED = 2'b01,
    SSW_WARMUP = 2'b11
  } ssw_pwr_e;
  typedef enum logic [1:0] {
    SSW_SRC_RC = 2'b00,
    SSW_SRC_XTAL = 2'b01,
    SSW_SRC_EXT = 2'b10
  } ssw_src_e;
  typedef struct packed {
    logic io_low;
    logic analog_low;
    logic core_low;
  } ssw_supply_s;
  typedef struct packed {
    ssw_src_e src;
    logic xtal_16m;
    logic [3:0] div_log2;
    logic rc_en;
    logic xtal_en;
    logic system_clock_run;
  } ssw_clk_s;
endpackage : ssw_pkg

// File: src/ssw_top.sv
// Purpose: reset sequencing, clock mode control, watchdog and irq gating
// Assumes: every non-APB input is asynchronous to pclk
// Notes: rc oscillator is sampled, so it must stay below pclk/2
`timescale 1ns/1ns
`default_nettype none
`include "ssw_defines.svh"
// How it works
// (R1) Hold core reset low while core rail is below reset threshold.
// (R2) Core fetches from reset vector 8000h once reset releases.
// (R3) Analog regulator starts off; software clears power-down bit to enable.
// (R4) Enabled brownout monitors raise sticky interrupt flags on low rails.
// (R5) Core rail dropping during run puts core back in reset.
// (R6) Clock source selects rc, crystal (8 or 16 MHz) or external.
// (R7) Watchdog counts rc cycles; divider tap sets interrupt interval.
// (R8) Interval expiry sets watchdog flag, then reset unless flag cleared.
// (R9) Default watchdog interval is 4096 rc cycles.
// (R10) Watchdog reset fires 512 rc cycles after the interrupt timeout.
// (R11) Any reset event restores default watchdog period selection.
// (R12) Two-bit period field picks later divider taps.
// (R13) Writing a new period before timeout restarts the count.
// (R14) Source divider gives system clock /1, /2, /4 or /8.
// (R15) Slow clock mode enable runs system clock at source/256.
// (R16) Switchback: enabled ext, CAN or SPI irq leaves slow mode.
// (R17) Stop bit halts both oscillators, system clock and processing.
// (R18) Stop ends only on enabled external irq or external reset.
// (R19) Stop exit waits for crystal or resumes on rc meanwhile.
// (R20) Irq reaches core only with individual, module, global enables set.
// (R21) After power-on the rc oscillator is the clock source.
// (R22) Internal resets drive the reset pin low.
// (R23) Clearing watchdog flag in time cancels reset, restarts interval.
module ssw_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ssw_pkg::ssw_supply_s supply_low,
  input wire logic core_rail_low,
  input wire logic rc_osc_clock,
  input wire logic xtal_ready,
  input wire logic ext_irq,
  input wire logic can_irq,
  input wire logic spi_irq,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output logic core_reset_n,
  output logic [15:0] reset_vector,
  output ssw_pkg::ssw_clk_s clk_ctrl,
  output logic analog_regulator_power_down,
  output logic core_irq
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int NS = 10;
  wire [NS-1:0] async_in = {supply_low, core_rail_low, rc_osc_clock,
    xtal_ready, ext_irq, can_irq, spi_irq, reset_pin_in};
  logic [NS-1:0] meta_q;
  logic [NS-1:0] sync_q;
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate
  wire [2:0] s_bo_low = sync_q[9:7];
  wire s_core_low = sync_q[6];
  wire s_rc = sync_q[5];
  wire s_xtal_ready = sync_q[4];
  wire s_ext = sync_q[3];
  wire s_can = sync_q[2];
  wire s_spi = sync_q[1];
  wire s_pin = sync_q[0];

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic rc_prev_q;
  logic [4:0] hold_q;
  logic [1:0] drive_tail_q;
  logic [9:0] clkcn_q;
  logic [9:0] clkcn_d;
  logic [3:0] watchdog_control_reg_q;
  logic por_q;
  logic [15:0] irqen_q;
  logic [2:0] bo_flag_q;
  logic xtal_warm_q;
  ssw_pkg::ssw_pwr_e pwr_q;
  ssw_pkg::ssw_pwr_e pwr_d;
  ssw_pkg::ssw_clk_s clk_d;
  logic wd_flag;
  logic wd_reset;

  // ----------------------------------------
  // reset sequencing
  // ----------------------------------------
  wire driving = s_core_low | (hold_q != 5'h00);
  // own drive echoes back through the synchroniser; mask it
  wire pin_echo = ~reset_pin_oe_n | (drive_tail_q != 2'b00);
  wire ext_rst = ~s_pin & ~driving & ~pin_echo;
  wire soft_rst = s_core_low | wd_reset | ext_rst; // [R5] [R11]
  wire core_hold = driving | ext_rst; // [R1] [R5]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= `SSW_RST_HOLD;
    end else if (s_core_low || wd_reset) begin
      hold_q <= `SSW_RST_HOLD;
    end else if (hold_q != 5'h00) begin
      hold_q <= hold_q - 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_tail_q <= 2'b11;
      reset_pin_oe_n <= 1'b0;
      reset_pin_out <= 1'b0;
      core_reset_n <= 1'b0;
      reset_vector <= `SSW_RESET_VECTOR;
    end else begin
      drive_tail_q <= {drive_tail_q[0], ~reset_pin_oe_n};
      reset_pin_oe_n <= ~driving; // [R22]
      reset_pin_out <= 1'b0;
      core_reset_n <= ~core_hold; // [R1] [R5]
      reset_vector <= `SSW_RESET_VECTOR; // [R2]
    end
  end

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  wire setup_done = psel & penable & ~pready;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire hit_clk = paddr == `SSW_OFF_CLKCN;
  wire hit_wd = paddr == `SSW_OFF_WATCHDOG_CONTROL_REG;
  wire hit_ie = paddr == `SSW_OFF_IRQEN;
  wire hit_fl = paddr == `SSW_OFF_IRQFL;
  wire hit_st = paddr == `SSW_OFF_STAT;
  wire mapped = hit_clk | hit_wd | hit_ie | hit_fl | hit_st;
  wire wr_clk = wr & hit_clk;
  wire wr_wd = wr & hit_wd;
  wire wr_ie = wr & hit_ie;
  wire wr_fl = wr & hit_fl;

  wire [31:0] rd_wd = {24'h0, por_q, 2'b00, wd_flag, watchdog_control_reg_q};
  wire [31:0] rd_fl = {25'h0, s_spi, s_can, s_ext, 1'b0, bo_flag_q};
  wire [31:0] rd_st = {24'h0, xtal_warm_q, pwr_q, core_reset_n,
    s_core_low, s_bo_low};
  wire [31:0] rd_data = hit_clk ? {22'h0, clkcn_q} :
    hit_wd ? rd_wd :
    hit_ie ? {16'h0, irqen_q} :
    hit_fl ? rd_fl :
    hit_st ? rd_st : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_done;
      prdata <= setup_done ? rd_data : 32'h0;
      pslverr <= setup_done & ~mapped;
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  wire [1:0] new_sel = pwdata[`SSW_WD_SEL+1:`SSW_WD_SEL];
  wire sel_written = wr_wd & (new_sel != watchdog_control_reg_q[`SSW_WD_SEL+1:`SSW_WD_SEL]); // [R13]
  wire flag_clear = wr_wd & pwdata[`SSW_WD_FLAG]; // [R23]
  // rc stops in stop mode, so the watchdog freezes too
  wire rc_tick = s_rc & ~rc_prev_q & (pwr_q != ssw_pkg::SSW_STOPPED); // [R7]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_prev_q <= 1'b0;
      watchdog_control_reg_q <= `SSW_WATCHDOG_CONTROL_REG_RST;
      por_q <= 1'b1;
    end else begin
      rc_prev_q <= s_rc;
      if (soft_rst) begin
        watchdog_control_reg_q <= `SSW_WATCHDOG_CONTROL_REG_RST; // [R11]
      end else if (wr_wd) begin
        watchdog_control_reg_q <= pwdata[3:0];
      end
      if (s_core_low) begin
        por_q <= 1'b1;
      end else if (wr_wd && !pwdata[`SSW_WD_POR]) begin
        por_q <= 1'b0;
      end
    end
  end

  ssw_wdog u_wdog (
    .pclk(pclk),
    .presetn(presetn),
    .rc_tick(rc_tick),
    .soft_rst(soft_rst),
    .enable(watchdog_control_reg_q[`SSW_WD_EN]),
    .rst_enable(watchdog_control_reg_q[`SSW_WD_RSTEN]),
    .period_sel(watchdog_control_reg_q[`SSW_WD_SEL+1:`SSW_WD_SEL]), // [R12]
    .sel_written(sel_written),
    .flag_clear(flag_clear),
    .flag_q(wd_flag),
    .wd_reset_q(wd_reset)
  );

  // ----------------------------------------
  // interrupt flags and gating
  // ----------------------------------------
  wire [2:0] bo_set = irqen_q[2:0] & s_bo_low; // [R4]
  wire [2:0] bo_clr = wr_fl ? pwdata[2:0] : 3'h0;
  wire [2:0] per_src = {s_spi, s_can, s_ext};
  wire [2:0] per_en = irqen_q[`SSW_IE_SPI:`SSW_IE_EXT];
  wire [2:0] per_pend = per_src & per_en & {3{irqen_q[`SSW_IE_MPER]}}; // [R20]
  wire sup_pend = |(bo_flag_q & irqen_q[2:0]) & irqen_q[`SSW_IE_MSUP];
  wire sys_pend = wd_flag & irqen_q[`SSW_IE_WD] & irqen_q[`SSW_IE_MSYS];
  wire irq_any = irqen_q[`SSW_IE_GLB] & (sup_pend | sys_pend | (|per_pend)); // [R20]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqen_q <= `SSW_IRQEN_RST;
      bo_flag_q <= 3'h0;
      core_irq <= 1'b0;
    end else begin
      if (soft_rst) begin
        irqen_q <= `SSW_IRQEN_RST;
      end else if (wr_ie) begin
        irqen_q <= pwdata[15:0];
      end
      // set beats a clear in the same cycle
      bo_flag_q <= (bo_flag_q & ~bo_clr) | bo_set; // [R4]
      core_irq <= irq_any & ~core_hold;
    end
  end

  // ----------------------------------------
  // clock modes and stop
  // ----------------------------------------
  wire slow_on = clkcn_q[`SSW_CLK_SLOW];
  wire switchback = clkcn_q[`SSW_CLK_SWB] & slow_on & (|per_pend); // [R16]
  wire ext_wake = s_ext & irqen_q[`SSW_IE_EXT]; // [R18]
  wire stop_exit = (pwr_q == ssw_pkg::SSW_STOPPED) & ext_wake;
  wire src_xtal = clkcn_q[1:0] == ssw_pkg::SSW_SRC_XTAL;

  always_comb begin
    clkcn_d = clkcn_q;
    if (wr_clk) begin
      clkcn_d = pwdata[9:0]; // [R3] [R14] [R15]
    end
    if (switchback) begin
      clkcn_d[`SSW_CLK_SLOW] = 1'b0; // [R16]
    end
    if (stop_exit) begin
      clkcn_d[`SSW_CLK_STOP] = 1'b0;
    end
  end

  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      ssw_pkg::SSW_RUN: begin
        if (clkcn_q[`SSW_CLK_STOP]) begin
          pwr_d = ssw_pkg::SSW_STOPPED; // [R17]
        end
      end
      ssw_pkg::SSW_STOPPED: begin
        if (ext_wake) begin // [R18] [R19]
          pwr_d = (clkcn_q[`SSW_CLK_WAITX] && src_xtal) ?
            ssw_pkg::SSW_WARMUP : ssw_pkg::SSW_RUN;
        end
      end
      ssw_pkg::SSW_WARMUP: begin
        if (s_xtal_ready) begin
          pwr_d = ssw_pkg::SSW_RUN; // [R19]
        end
      end
      default: begin
        pwr_d = ssw_pkg::SSW_RUN;
      end
    endcase
  end

  always_comb begin
    clk_d.src = xtal_warm_q ? ssw_pkg::SSW_SRC_RC :
      ssw_pkg::ssw_src_e'(clkcn_q[1:0]); // [R6] [R19]
    clk_d.xtal_16m = clkcn_q[`SSW_CLK_X16]; // [R6]
    clk_d.div_log2 = slow_on ? `SSW_SLOW_DIV_LOG2 :
      {2'b00, clkcn_q[`SSW_CLK_DIV+1:`SSW_CLK_DIV]}; // [R14] [R15]
    clk_d.rc_en = pwr_q != ssw_pkg::SSW_STOPPED; // [R17]
    clk_d.xtal_en = (pwr_q != ssw_pkg::SSW_STOPPED) & src_xtal; // [R17]
    clk_d.system_clock_run = pwr_q == ssw_pkg::SSW_RUN; // [R17]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkcn_q <= `SSW_CLKCN_RST; // [R3] [R21]
      pwr_q <= ssw_pkg::SSW_RUN;
      xtal_warm_q <= 1'b0;
      clk_ctrl <= '0;
      analog_regulator_power_down <= 1'b1;
    end else begin
      if (soft_rst) begin
        clkcn_q <= `SSW_CLKCN_RST; // [R18] [R21]
        pwr_q <= ssw_pkg::SSW_RUN;
        xtal_warm_q <= 1'b0;
      end else begin
        clkcn_q <= clkcn_d;
        pwr_q <= pwr_d;
        // resume on rc until the crystal reports ready
        if (stop_exit && src_xtal && !clkcn_q[`SSW_CLK_WAITX]) begin
          xtal_warm_q <= 1'b1; // [R19]
        end else if (s_xtal_ready) begin
          xtal_warm_q <= 1'b0;
        end
      end
      clk_ctrl <= clk_d;
      analog_regulator_power_down <= clkcn_q[`SSW_CLK_ARPD]; // [R3]
    end
  end
endmodule : ssw_top
`default_nettype wire

// File: src/ssw_wdog.sv
// Purpose: watchdog interval and reset delay counters
// Assumes: rc_tick is a one-cycle pulse per rc oscillator cycle
// Notes: counts only rc ticks, so pclk rate does not matter
`timescale 1ns/1ns
`default_nettype none
`include "ssw_defines.svh"
module ssw_wdog #(
  parameter int BASE_LOG2 = `SSW_WD_BASE_LOG2,
  parameter int RST_TICKS = `SSW_WD_RST_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rc_tick,
  input wire logic soft_rst,
  input wire logic enable,
  input wire logic rst_enable,
  input wire logic [1:0] period_sel,
  input wire logic sel_written,
  input wire logic flag_clear,
  output logic flag_q,
  output logic wd_reset_q
);
  localparam int CW = BASE_LOG2 + 10;
  logic [CW-1:0] cnt_q;
  logic [9:0] rcnt_q;
  wire [5:0] tap = 6'(BASE_LOG2) + 6'({period_sel, 1'b0} + period_sel);
  wire [CW-1:0] limit = CW'((64'd1 << tap) - 64'd1);
  wire timeout = enable & rc_tick & ~flag_q & (cnt_q == limit); // [R7] [R9] [R12]
  wire rst_due = flag_q & rc_tick & (rcnt_q == 10'(RST_TICKS - 1)); // [R10]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      rcnt_q <= '0;
      flag_q <= 1'b0;
      wd_reset_q <= 1'b0;
    end else if (soft_rst) begin
      cnt_q <= '0;
      rcnt_q <= '0;
      flag_q <= 1'b0;
      wd_reset_q <= 1'b0;
    end else begin
      // period change before timeout restarts the count
      if (!enable || sel_written || timeout || flag_clear) begin // [R13] [R23]
        cnt_q <= '0;
      end else if (rc_tick && !flag_q) begin
        cnt_q <= cnt_q + 1'b1;
      end
      // a timeout in the clearing cycle still sets the flag
      if (timeout) begin // [R8]
        flag_q <= 1'b1;
      end else if (flag_clear || !enable) begin // [R23]
        flag_q <= 1'b0;
      end
      if (!flag_q || flag_clear) begin
        rcnt_q <= '0;
      end else if (rc_tick) begin
        rcnt_q <= rcnt_q + 1'b1;
      end
      wd_reset_q <= rst_due & rst_enable & ~flag_clear; // [R8] [R10]
    end
  end
endmodule : ssw_wdog
`default_nettype wire

// File: verif/ssw_far_model.sv
// Purpose: oscillators and reset wire around the supervisor
// Assumes: rc runs at pclk/4 while enabled
// Notes: crystal needs 15 cycles of enable to settle
`timescale 1ns/1ns
`default_nettype none
module ssw_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire ssw_pkg::ssw_clk_s clk_ctrl,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic ext_reset_n,
  output logic rc_osc_clock,
  output logic xtal_ready,
  output logic reset_pin_in
);
  logic ph_q;
  logic [3:0] warm_q;
  // pulled up; either party may pull low
  assign reset_pin_in = (reset_pin_oe_n | reset_pin_out) & ext_reset_n;
  assign xtal_ready = (warm_q == 4'hf);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 1'b0;
      rc_osc_clock <= 1'b0;
      warm_q <= 4'h0;
    end else begin
      // stands still once the block halts it
      if (clk_ctrl.rc_en) begin
        ph_q <= ~ph_q;
        if (ph_q) begin
          rc_osc_clock <= ~rc_osc_clock;
        end
      end
      warm_q <= !clk_ctrl.xtal_en ? 4'h0 : (xtal_ready ? warm_q : warm_q + 4'h1);
    end
  end
endmodule : ssw_far_model
`default_nettype wire

// File: verif/ssw_top_checker.sv
// Purpose: port-level checks of ssw_top
// Assumes: one wait state apb, pin inputs synced in two stages
// Notes: bound to ssw_top at the foot
`timescale 1ns/1ns
`default_nettype none
module ssw_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic core_rail_low,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic core_reset_n,
  input wire logic [15:0] reset_vector,
  input wire ssw_pkg::ssw_clk_s clk_ctrl,
  input wire logic analog_regulator_power_down,
  input wire logic core_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  AST_APB_WAIT: assert property (s_setup ##1 s_access |=> pready) else $error("pready late");
  AST_APB_PULSE: assert property (pready |=> !pready) else $error("pready held");
  AST_APB_ERR: assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_APB_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  AST_VECTOR: assert property (reset_vector == 16'h8000) else $error("reset vector moved");
  AST_PIN_LEVEL: assert property (reset_pin_out == 1'b0) else $error("pin driven high");
  // five samples cover the two sync stages, the output flop and margin
  AST_RAIL_RESET: assert property (core_rail_low [*5] |-> !core_reset_n && !reset_pin_oe_n)
    else $error("rail low not in reset");
  AST_IRQ_QUIET: assert property (!core_reset_n [*2] |-> !core_irq) else $error("irq in reset");
  AST_STOP_OSC: assert property ($fell(clk_ctrl.system_clock_run) |-> !clk_ctrl.rc_en && !clk_ctrl.xtal_en)
    else $error("oscillator runs in stop");
  AST_ANALOG_OFF: assert property ($rose(core_reset_n) |-> analog_regulator_power_down)
    else $error("analog regulator on at boot");
endmodule : ssw_top_checker
bind ssw_top ssw_top_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_rail_low(core_rail_low),
  .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n), .core_reset_n(core_reset_n),
  .reset_vector(reset_vector), .clk_ctrl(clk_ctrl), .analog_regulator_power_down(analog_regulator_power_down),
  .core_irq(core_irq));
`default_nettype wire

// File: verif/tb.sv
// Purpose: self-checking bench for ssw_top
// Assumes: one wait state apb
// Notes: watchdog runs its full default counts
`timescale 1ns/1ns
`default_nettype none
`include "ssw_defines.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rc_osc_clock, xtal_ready, reset_pin_in, reset_pin_out, reset_pin_oe_n;
  logic core_rail_low = 1'b0, ext_irq = 1'b0, can_irq = 1'b0, spi_irq = 1'b0, ext_reset_n = 1'b1;
  logic core_reset_n, analog_regulator_power_down, core_irq;
  logic [15:0] reset_vector;
  ssw_pkg::ssw_supply_s supply_low = 3'b000;
  ssw_pkg::ssw_clk_s clk_ctrl;
  int fails = 0, num_checks = 0, cyc = 0, n, t0;
  ssw_top i_ssw_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_low(supply_low), .core_rail_low(core_rail_low), .rc_osc_clock(rc_osc_clock),
    .xtal_ready(xtal_ready), .ext_irq(ext_irq), .can_irq(can_irq), .spi_irq(spi_irq),
    .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
    .core_reset_n(core_reset_n), .reset_vector(reset_vector), .clk_ctrl(clk_ctrl),
    .analog_regulator_power_down(analog_regulator_power_down), .core_irq(core_irq));
  ssw_far_model i_ssw_far_model (.pclk(pclk), .presetn(presetn), .clk_ctrl(clk_ctrl),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n), .ext_reset_n(ext_reset_n),
    .rc_osc_clock(rc_osc_clock), .xtal_ready(xtal_ready), .reset_pin_in(reset_pin_in));
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d, errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : tick
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rchk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd & mask, exp);
  endtask : rchk
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    tick(3);
    check(core_reset_n, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    for (n = 0; n < 40 && core_reset_n !== 1'b1; n++) tick(1);
    check(core_reset_n, 1'b1);
    check(clk_ctrl.src, ssw_pkg::SSW_SRC_RC);
    rchk(`SSW_OFF_CLKCN, 32'h3ff, 32'h200);
    rchk(12'h014, 32'hffffffff, 32'h0);
    check(err, 1'b1);
    xfer(1'b1, `SSW_OFF_CLKCN, 32'h0);
    tick(2);
    check(analog_regulator_power_down, 1'b0);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, `SSW_OFF_CLKCN, (k << 3) | ((k & 1) << 2) | (k % 3));
      tick(2);
      check(clk_ctrl.div_log2, k);
      check(clk_ctrl.xtal_16m, k & 1);
      check(clk_ctrl.src, k % 3);
    end
    xfer(1'b1, `SSW_OFF_IRQEN, 32'h8770);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, `SSW_OFF_CLKCN, 32'h060);
      tick(2);
      check(clk_ctrl.div_log2, 4'h8);
      @(posedge pclk);
      {spi_irq, can_irq, ext_irq} <= 3'(1 << i);
      for (n = 0; n < 20 && clk_ctrl.div_log2 === 4'h8; n++) tick(1);
      check(clk_ctrl.div_log2, 4'h0);
      rchk(`SSW_OFF_CLKCN, 32'h20, 32'h0);
      {spi_irq, can_irq, ext_irq} <= 3'b000;
    end
    xfer(1'b1, `SSW_OFF_CLKCN, 32'h080);
    tick(2);
    check({clk_ctrl.system_clock_run, clk_ctrl.rc_en, clk_ctrl.xtal_en}, 3'b000);
    @(posedge pclk);
    can_irq <= 1'b1;
    tick(20);
    check(clk_ctrl.system_clock_run, 1'b0);
    @(posedge pclk);
    ext_irq <= 1'b1;
    for (n = 0; n < 20 && clk_ctrl.system_clock_run !== 1'b1; n++) tick(1);
    check(clk_ctrl.system_clock_run, 1'b1);
    @(posedge pclk);
    {can_irq, ext_irq} <= 2'b00;
    for (int w = 1; w >= 0; w--) begin
      xfer(1'b1, `SSW_OFF_CLKCN, 32'h081 | (w << 8));
      tick(4);
      @(posedge pclk);
      ext_irq <= 1'b1;
      for (n = 0; n < 20 && clk_ctrl.xtal_en !== 1'b1; n++) tick(1);
      check({clk_ctrl.system_clock_run, clk_ctrl.src}, w ? 3'b001 : 3'b100);
      tick(30);
      check({clk_ctrl.system_clock_run, clk_ctrl.src}, 3'b101);
      @(posedge pclk);
      ext_irq <= 1'b0;
    end
    xfer(1'b1, `SSW_OFF_CLKCN, 32'h080);
    tick(4);
    @(posedge pclk);
    ext_reset_n <= 1'b0;
    tick(6);
    check({core_reset_n, clk_ctrl.system_clock_run}, 2'b01);
    @(posedge pclk);
    ext_reset_n <= 1'b1;
    for (n = 0; n < 40 && core_reset_n !== 1'b1; n++) tick(1);
    check(core_reset_n, 1'b1);
    rchk(`SSW_OFF_CLKCN, 32'h3ff, 32'h200);
    xfer(1'b1, `SSW_OFF_IRQEN, 32'h8107);
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      supply_low <= 3'(1 << i);
      tick(6);
      check(core_irq, 1'b1);
      rchk(`SSW_OFF_IRQFL, 32'h7, 1 << i);
      supply_low <= 3'b000;
      xfer(1'b1, `SSW_OFF_IRQFL, 32'h7);
      tick(3);
      check(core_irq, 1'b0);
    end
    xfer(1'b1, `SSW_OFF_IRQEN, 32'h0107);
    supply_low <= 3'b100;
    tick(6);
    check(core_irq, 1'b0);
    rchk(`SSW_OFF_IRQFL, 32'h7, 32'h4);
    supply_low <= 3'b000;
    xfer(1'b1, `SSW_OFF_IRQFL, 32'h7);
    @(posedge pclk);
    core_rail_low <= 1'b1;
    tick(8);
    check({core_reset_n, reset_pin_oe_n}, 2'b00);
    @(posedge pclk);
    core_rail_low <= 1'b0;
    for (n = 0; n < 40 && core_reset_n !== 1'b1; n++) tick(1);
    check(core_reset_n, 1'b1);
    rchk(`SSW_OFF_CLKCN, 32'h3ff, 32'h200);
    xfer(1'b1, `SSW_OFF_IRQEN, 32'h8208);
    xfer(1'b1, `SSW_OFF_WATCHDOG_CONTROL_REG, 32'h7);
    xfer(1'b1, `SSW_OFF_WATCHDOG_CONTROL_REG, 32'h3);
    t0 = cyc;
    for (n = 0; n < 17000 && core_irq !== 1'b1; n++) tick(1);
    check((cyc - t0 >= 16376) && (cyc - t0 <= 16400), 1'b1);
    t0 = cyc;
    rchk(`SSW_OFF_WATCHDOG_CONTROL_REG, 32'h10, 32'h10);
    xfer(1'b1, `SSW_OFF_WATCHDOG_CONTROL_REG, 32'h0f);
    for (n = 0; n < 2200 && core_reset_n !== 1'b0; n++) tick(1);
    check((cyc - t0 >= 2036) && (cyc - t0 <= 2060), 1'b1);
    check(reset_pin_oe_n, 1'b0);
    for (n = 0; n < 40 && core_reset_n !== 1'b1; n++) tick(1);
    rchk(`SSW_OFF_WATCHDOG_CONTROL_REG, 32'h0f, 32'h0);
    xfer(1'b1, `SSW_OFF_IRQEN, 32'h8208);
    xfer(1'b1, `SSW_OFF_WATCHDOG_CONTROL_REG, 32'h3);
    for (n = 0; n < 17000 && core_irq !== 1'b1; n++) tick(1);
    check(core_irq, 1'b1);
    xfer(1'b1, `SSW_OFF_WATCHDOG_CONTROL_REG, 32'h13);
    tick(2300);
    check({core_reset_n, core_irq}, 2'b10);
    xfer(1'b1, `SSW_OFF_WATCHDOG_CONTROL_REG, 32'h0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
